// *** shared/sct_params.svh ***
// Purpose: Offsets, field positions, reset values and counts for sct.
// Assumes: Byte-wide registers on a plain strobe port.
// Notes:   Definitions only.
`ifndef SCT_PARAMS_SVH
`define SCT_PARAMS_SVH
`define SCT_ADDR_TRIM        4'h0
`define SCT_ADDR_DIVCTL      4'h1
`define SCT_ADDR_ASYNC       4'h2
`define SCT_ADDR_STATUS      4'h3
`define SCT_UNLOCK_BIT       7
`define SCT_ASYNC_EN_BIT     0
`define SCT_ASYNC_EXTERNAL_CLOCK_SELECT_BIT       1
`define SCT_SEL_RST_NOFUSE   4'h0
`define SCT_SEL_RST_FUSE     4'h3
`define SCT_SEL_MAX          4'h8
`define SCT_LIMIT_MAX        8'hff
`define SCT_UNLOCK_CYCLES    3'h4
`define SCT_UNLOCK_VALUE     8'h80
`define SCT_CLK_PERIOD_NS    100
`endif

// *** shared/sct_pkg.sv ***
// Purpose: Types shared by the clock control block.
// Assumes: Constants come from sct_params.svh.
// Notes:   None.
`default_nettype none
package sct_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sct_bus_s;
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
  } sct_domain_en_s;
  typedef enum logic {
    SCT_LOCKED = 1'b0,
    SCT_OPEN   = 1'b1
  } sct_unlock_e;
endpackage
`default_nettype wire

// *** core/sct_divider.sv ***
// Purpose: Prescaler counter giving one enable pulse per divided period.
// Assumes: Runs on the undivided source clock.
// Notes:   New factors are taken only at a period boundary.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"
module sct_divider #(
  parameter int CNT_W = 8
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [3:0]       sel,
  output logic                  tick,
  output logic [CNT_W-1:0]      limit
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit_reg;
  logic [CNT_W-1:0] limit_next;
  logic [CNT_W-1:0] gap_reg;
  logic [CNT_W-1:0] lim_prev_reg;
  logic             seen_reg;

  // Factor is two to the power of the select; reserved codes give 256.
  always_comb begin
    if (sel > `SCT_SEL_MAX) begin
      limit_next = CNT_W'(`SCT_LIMIT_MAX);
    end else begin
      limit_next = CNT_W'((9'h001 << sel) - 9'h001);
    end
  end

  assign tick  = (cnt_reg == limit_reg);
  assign limit = limit_reg;

  // Count wraps at the limit; the limit only changes at the wrap.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_reg   <= '0;
      limit_reg <= limit_next;
    end else if (tick) begin
      cnt_reg   <= '0;
      limit_reg <= limit_next;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Helper state for the checks below.
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_reg      <= '0;
      lim_prev_reg <= '0;
      seen_reg     <= 1'b0;
    end else if (tick) begin
      gap_reg      <= '0;
      lim_prev_reg <= limit_next;
      seen_reg     <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  property p_no_fast_period;
    @(posedge clk) disable iff (srst)
      (tick && seen_reg) |-> (gap_reg == lim_prev_reg);
  endproperty
  a_no_fast_period: assert property (p_no_fast_period)
    else $error("Divided period differs from the active setting.");

  property p_div8_decode;
    @(posedge clk) disable iff (srst)
      (tick && sel == 4'h3) |=> (limit_reg == 8'h07);
  endproperty
  a_div8_decode: assert property (p_div8_decode)
    else $error("Select three did not give divide by eight.");

  property p_reserved_max;
    @(posedge clk) disable iff (srst)
      (tick && sel > 4'h8) |=> (limit_reg == 8'hff);
  endproperty
  a_reserved_max: assert property (p_reserved_max)
    else $error("Reserved select did not give divide by 256.");

  sequence s_sel_change;
    !$stable(sel);
  endsequence
  property p_switch_time;
    @(posedge clk) disable iff (srst)
      s_sel_change |-> ##[0:256] tick ##1 (limit_reg == limit_next);
  endproperty
  a_switch_time: assert property (p_switch_time)
    else $error("New factor not active within one old period.");
endmodule // sct_divider
`default_nettype wire

// *** core/sct_clock_ctrl.sv ***
// Purpose: System clock prescaler, RC trim and timer oscillator control.
// Assumes: MCLK is the undivided source clock at 10 MHz; pins are static.
// Notes:   Divided clocks leave as per-cycle enables to gate MCLK.
// Functional notes
// - Timer oscillator on shared pins only while RC oscillator is source.
// - External clock select lets timer input pin take an external clock.
// - Clock output fuse drives clock pin, also in reset, overriding I/O.
// - Clock output carries the divided clock when the prescaler divides.
// - CPU, flash, I/O and ADC enables share one divided tick.
// - Factor change makes no glitch and no faster intermediate period.
// - New factor takes effect after old period plus one or two new; the divider loads it at the next tick, within one old period.
// - Prescaler counts at source rate; its count is never readable.
// - Unlock bit updates only when all other divider bits are zero.
// - Unlock clears four cycles after set or on a select write.
// - Rewriting unlock during the window neither extends nor clears it.
// - Select encodes divide by two to its power, one up to 256.
// - Reset loads select 0 or 3 from the divide-by-eight fuse.
// - Unlocked writes may set any select regardless of the fuse.
// - Reset loads factory trim value; software writes retune oscillator.
// - Top trim bit picks low or high, overlapping, range.
// - Lower seven trim bits tune within the range, low to high.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"
module sct_clock_ctrl #(
  parameter int CNT_W = 8
) (
  input  wire logic                    MCLK,
  input  wire logic                    SRST,
  input  wire sct_pkg::sct_bus_s       BUS,
  output logic [7:0]                   RDATA,
  input  wire logic                    CLOCK_OUTPUT_FUSE,
  input  wire logic                    INITIAL_DIVIDE_BY_EIGHT_FUSE,
  input  wire logic                    RC_SOURCE_SELECTED,
  input  wire logic [7:0]              FACTORY_TRIM,
  output sct_pkg::sct_domain_en_s      DOMAIN_CLK_EN,
  output logic                         CLOCK_OUTPUT_PIN_GATE,
  output logic                         CLOCK_OUTPUT_PIN_OE,
  output logic                         TRIM_RANGE_BIT,
  output logic [6:0]                   TRIM_FINE_FIELD,
  output logic                         TIMER_OSC_ENABLE,
  output logic                         TIMER_OSC_EXT_CLOCK
);
  import sct_pkg::*;

  logic [1:0]       clock_output_fuse_sync;
  logic [1:0]       div8_sync;
  logic [1:0]       rcsel_sync;
  logic [7:0]       trim_meta;
  logic [7:0]       trim_sync;
  logic             clock_output_fuse_s;
  logic             div8_s;
  logic             rcsel_s;

  logic [7:0]       trim_reg;
  logic [3:0]       sel_reg;
  sct_unlock_e      unlock_reg;
  logic [2:0]       unlock_cnt_reg;
  logic [2:0]       open_len_reg;
  logic             async_en_reg;
  logic             async_external_clock_select_reg;
  logic [7:0]       rdata_reg;

  logic             wr_div;
  logic             clean_unlock;
  logic             sel_write;
  logic             tick;
  logic [CNT_W-1:0] limit;

  // Two-stage synchronisers; left unreset so straps settle during reset.
  always_ff @(posedge MCLK) begin
    clock_output_fuse_sync <= {clock_output_fuse_sync[0], CLOCK_OUTPUT_FUSE};
    div8_sync  <= {div8_sync[0], INITIAL_DIVIDE_BY_EIGHT_FUSE};
    rcsel_sync <= {rcsel_sync[0], RC_SOURCE_SELECTED};
    trim_meta  <= FACTORY_TRIM;
    trim_sync  <= trim_meta;
  end
  assign clock_output_fuse_s = clock_output_fuse_sync[1];
  assign div8_s  = div8_sync[1];
  assign rcsel_s = rcsel_sync[1];

  assign wr_div       = BUS.wr && (BUS.addr == `SCT_ADDR_DIVCTL);
  assign clean_unlock = wr_div && (BUS.wdata == `SCT_UNLOCK_VALUE);
  assign sel_write    = wr_div && !BUS.wdata[`SCT_UNLOCK_BIT] &&
                        (unlock_reg == SCT_OPEN);

  // Oscillator trim: factory value in reset, software value after.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      trim_reg <= trim_sync;
    end else if (BUS.wr && BUS.addr == `SCT_ADDR_TRIM) begin
      trim_reg <= BUS.wdata;
    end
  end
  assign TRIM_RANGE_BIT  = trim_reg[7];
  assign TRIM_FINE_FIELD = trim_reg[6:0];

  // Divider select, reset value from the fuse, changed only when unlocked.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sel_reg <= div8_s ? `SCT_SEL_RST_FUSE : `SCT_SEL_RST_NOFUSE;
    end else if (sel_write) begin
      sel_reg <= BUS.wdata[3:0];
    end
  end

  // Unlock window: opened by a clean write, closed by timeout or select.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      unlock_reg     <= SCT_LOCKED;
      unlock_cnt_reg <= 3'h0;
    end else begin
      case (unlock_reg)
        SCT_LOCKED: begin
          if (clean_unlock) begin
            unlock_reg     <= SCT_OPEN;
            unlock_cnt_reg <= `SCT_UNLOCK_CYCLES;
          end
        end
        SCT_OPEN: begin
          if (sel_write || unlock_cnt_reg == 3'h1) begin
            unlock_reg     <= SCT_LOCKED;
            unlock_cnt_reg <= 3'h0;
          end else begin
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
          end
        end
        default: begin
          unlock_reg     <= SCT_LOCKED;
          unlock_cnt_reg <= 3'h0;
        end
      endcase
    end
  end

  // Asynchronous timer control bits.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      async_en_reg <= 1'b0;
      async_external_clock_select_reg   <= 1'b0;
    end else if (BUS.wr && BUS.addr == `SCT_ADDR_ASYNC) begin
      async_en_reg <= BUS.wdata[`SCT_ASYNC_EN_BIT];
      async_external_clock_select_reg   <= BUS.wdata[`SCT_ASYNC_EXTERNAL_CLOCK_SELECT_BIT];
    end
  end
  assign TIMER_OSC_ENABLE    = async_en_reg && rcsel_s;
  assign TIMER_OSC_EXT_CLOCK = TIMER_OSC_ENABLE && async_external_clock_select_reg;

  sct_divider #(
    .CNT_W (CNT_W)
  ) u_divider (
    .clk   (MCLK),
    .srst  (SRST),
    .sel   (sel_reg),
    .tick  (tick),
    .limit (limit)
  );

  // All synchronous domains run from the same divided tick.
  always_comb begin
    DOMAIN_CLK_EN.cpu   = tick;
    DOMAIN_CLK_EN.flash = tick;
    DOMAIN_CLK_EN.io    = tick;
    DOMAIN_CLK_EN.adc   = tick;
  end

  // Clock pin: undivided source in reset, divided clock afterwards.
  assign CLOCK_OUTPUT_PIN_OE   = clock_output_fuse_s;
  assign CLOCK_OUTPUT_PIN_GATE = clock_output_fuse_s && (SRST || tick);

  // Read port; the prescaler count itself is not mapped.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rdata_reg <= 8'h00;
    end else if (BUS.rd) begin
      if (BUS.addr == `SCT_ADDR_TRIM) begin
        rdata_reg <= trim_reg;
      end else if (BUS.addr == `SCT_ADDR_DIVCTL) begin
        rdata_reg <= {unlock_reg == SCT_OPEN, 3'h0, sel_reg};
      end else if (BUS.addr == `SCT_ADDR_ASYNC) begin
        rdata_reg <= {6'h00, async_external_clock_select_reg, async_en_reg};
      end else if (BUS.addr == `SCT_ADDR_STATUS) begin
        rdata_reg <= {4'h0, rcsel_s, TIMER_OSC_EXT_CLOCK,
                      TIMER_OSC_ENABLE, clock_output_fuse_s};
      end else begin
        rdata_reg <= 8'h00;
      end
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign RDATA = rdata_reg;

  sequence s_open_req;
    (unlock_reg == SCT_LOCKED) && clean_unlock;
  endsequence
  sequence s_no_select_4;
    (!sel_write) [*4];
  endsequence

  property p_unlock_opens;
    @(posedge MCLK) disable iff (SRST)
      s_open_req |=> (unlock_reg == SCT_OPEN);
  endproperty
  a_unlock_opens: assert property (p_unlock_opens)
    else $error("Clean unlock write did not open the window.");

  property p_dirty_unlock;
    @(posedge MCLK) disable iff (SRST)
      (unlock_reg == SCT_LOCKED && wr_div && BUS.wdata[7] &&
       BUS.wdata[6:0] != 7'h00) |=> (unlock_reg == SCT_LOCKED);
  endproperty
  a_dirty_unlock: assert property (p_dirty_unlock)
    else $error("Unlock set by a write with other bits set.");

  property p_timeout;
    @(posedge MCLK) disable iff (SRST)
      s_open_req ##1 s_no_select_4 |=> (unlock_reg == SCT_LOCKED);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Unlock window not closed after four cycles.");

  property p_open_holds;
    @(posedge MCLK) disable iff (SRST)
      s_open_req ##1 (!sel_write) [*3] |-> (unlock_reg == SCT_OPEN);
  endproperty
  a_open_holds: assert property (p_open_holds)
    else $error("Unlock window closed early.");

  property p_select_closes;
    @(posedge MCLK) disable iff (SRST)
      sel_write |=> (unlock_reg == SCT_LOCKED) &&
        (sel_reg == $past(BUS.wdata[3:0]));
  endproperty
  a_select_closes: assert property (p_select_closes)
    else $error("Select write not taken or window left open.");

  property p_reset_select;
    @(posedge MCLK) $fell(SRST) |->
      (sel_reg == ($past(div8_s) ? 4'h3 : 4'h0));
  endproperty
  a_reset_select: assert property (p_reset_select)
    else $error("Select reset value does not follow the fuse.");

  property p_reset_trim;
    @(posedge MCLK) $fell(SRST) |-> (trim_reg == $past(trim_sync));
  endproperty
  a_reset_trim: assert property (p_reset_trim)
    else $error("Factory trim not loaded in reset.");

  property p_clock_output_pin_reset;
    @(posedge MCLK) (SRST && clock_output_fuse_s) |->
      (CLOCK_OUTPUT_PIN_OE && CLOCK_OUTPUT_PIN_GATE);
  endproperty
  a_clock_output_pin_reset: assert property (p_clock_output_pin_reset)
    else $error("Clock pin not driven during reset.");

  property p_clock_output_pin_divided;
    @(posedge MCLK) disable iff (SRST)
      (clock_output_fuse_s && limit != '0 && CLOCK_OUTPUT_PIN_GATE) |=>
        (!CLOCK_OUTPUT_PIN_GATE || limit == '0);
  endproperty
  a_clock_output_pin_divided: assert property (p_clock_output_pin_divided)
    else $error("Clock pin passes undivided clock while dividing.");

  property p_tosc_rc_only;
    @(posedge MCLK) disable iff (SRST)
      TIMER_OSC_ENABLE |-> rcsel_s && async_en_reg;
  endproperty
  a_tosc_rc_only: assert property (p_tosc_rc_only)
    else $error("Timer oscillator enabled without RC source.");

  // Length of the current unlock window, for the check below.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      open_len_reg <= 3'h0;
    end else if (unlock_reg == SCT_OPEN) begin
      open_len_reg <= open_len_reg + 3'h1;
    end else begin
      open_len_reg <= 3'h0;
    end
  end

  property p_open_len;
    @(posedge MCLK) disable iff (SRST)
      (open_len_reg <= `SCT_UNLOCK_CYCLES);
  endproperty
  a_open_len: assert property (p_open_len)
    else $error("Unlock window stayed open too long.");

  property p_trim_write;
    @(posedge MCLK) disable iff (SRST)
      (BUS.wr && BUS.addr == `SCT_ADDR_TRIM) |=>
        (trim_reg == $past(BUS.wdata));
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("Trim write not taken.");

  property p_async_write;
    @(posedge MCLK) disable iff (SRST)
      (BUS.wr && BUS.addr == `SCT_ADDR_ASYNC) |=>
        (async_external_clock_select_reg == $past(BUS.wdata[`SCT_ASYNC_EXTERNAL_CLOCK_SELECT_BIT]));
  endproperty
  a_async_write: assert property (p_async_write)
    else $error("External clock select write not taken.");

  property p_div_read;
    @(posedge MCLK) disable iff (SRST)
      (BUS.rd && BUS.addr == `SCT_ADDR_DIVCTL) |=>
        (RDATA[6:4] == 3'h0) && (RDATA[3:0] == $past(sel_reg));
  endproperty
  a_div_read: assert property (p_div_read)
    else $error("Divider control read shows more than the select.");

  property p_rdata_idle;
    @(posedge MCLK) disable iff (SRST)
      !BUS.rd |=> (RDATA == 8'h00);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data present without a read.");

  property p_locked_hold;
    @(posedge MCLK) disable iff (SRST)
      (unlock_reg == SCT_LOCKED) |=> $stable(sel_reg);
  endproperty
  a_locked_hold: assert property (p_locked_hold)
    else $error("Select changed while the window was closed.");

  property p_domains_same;
    @(posedge MCLK) disable iff (SRST)
      (DOMAIN_CLK_EN == {4{tick}});
  endproperty
  a_domains_same: assert property (p_domains_same)
    else $error("Domain enables disagree with the divided tick.");

  property p_ext_needs_en;
    @(posedge MCLK) disable iff (SRST)
      TIMER_OSC_EXT_CLOCK |-> TIMER_OSC_ENABLE;
  endproperty
  a_ext_needs_en: assert property (p_ext_needs_en)
    else $error("External clock accepted with timer oscillator off.");

  property p_clock_output_pin_off;
    @(posedge MCLK) !clock_output_fuse_s |->
      (!CLOCK_OUTPUT_PIN_OE && !CLOCK_OUTPUT_PIN_GATE);
  endproperty
  a_clock_output_pin_off: assert property (p_clock_output_pin_off)
    else $error("Clock pin driven without the fuse.");
endmodule // sct_clock_ctrl
`default_nettype wire

// *** tb/sct_testbench.sv ***
// Purpose: Self-checking bench for the clock control block.
// Assumes: Register port with one-cycle strobes; fuses static per reset.
// Notes:   Enables are sampled 1 ns after each rising MCLK edge.
`timescale 1ns/1ps
`default_nettype none
`include "sct_params.svh"
module testbench;
  import sct_pkg::*;
  `define TB_CHK(nm, ex, got) \
    begin \
      checks_done++; \
      if ((got) !== (ex)) begin \
        $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
        mismatches++; \
      end \
    end

  logic           mclk;
  logic           srst;
  sct_bus_s       bus;
  logic [7:0]     rdata;
  logic           fuse_clk_out;
  logic           fuse_div8;
  logic           rc_src;
  logic [7:0]     factory_trim;
  sct_domain_en_s dom_en;
  logic           pin_gate;
  logic           pin_oe;
  logic           trim_range;
  logic [6:0]     trim_fine;
  logic           tosc_en;
  logic           tosc_ext;
  int             mismatches;
  int             checks_done;
  logic [7:0]     rd_val;
  int             g1;
  int             g2;
  int             g3;
  int             oldp;
  int             newp;
  logic [3:0]     cur_sel;
  logic [3:0]     sv;

  sct_clock_ctrl dut (
    .MCLK                         (mclk),
    .SRST                         (srst),
    .BUS                          (bus),
    .RDATA                        (rdata),
    .CLOCK_OUTPUT_FUSE            (fuse_clk_out),
    .INITIAL_DIVIDE_BY_EIGHT_FUSE (fuse_div8),
    .RC_SOURCE_SELECTED           (rc_src),
    .FACTORY_TRIM                 (factory_trim),
    .DOMAIN_CLK_EN                (dom_en),
    .CLOCK_OUTPUT_PIN_GATE        (pin_gate),
    .CLOCK_OUTPUT_PIN_OE          (pin_oe),
    .TRIM_RANGE_BIT               (trim_range),
    .TRIM_FINE_FIELD              (trim_fine),
    .TIMER_OSC_ENABLE             (tosc_en),
    .TIMER_OSC_EXT_CLOCK          (tosc_ext)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] ex,
                        input string nm);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    rd_val = rdata;
    `TB_CHK(nm, ex, rd_val)
  endtask

  task automatic set_sel(input logic [3:0] s);
    wr_reg(`SCT_ADDR_DIVCTL, `SCT_UNLOCK_VALUE);
    wr_reg(`SCT_ADDR_DIVCTL, {4'h0, s});
  endtask

  // Counts cycles up to the next divided tick, bounded.
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      `TB_CHK("domain enables", {4{dom_en.cpu}}, dom_en)
      if (fuse_clk_out) `TB_CHK("pin gate", dom_en.cpu, pin_gate)
      `TB_CHK("pin enable", fuse_clk_out, pin_oe)
    end while (dom_en.cpu !== 1'b1 && n < 600);
    if (n >= 600) begin
      mismatches++;
      print_verdict();
    end
  endtask

  task automatic do_reset(input logic co, input logic d8);
    @(posedge mclk);
    srst <= 1'b1;
    fuse_clk_out <= co;
    fuse_div8 <= d8;
    repeat (10) @(posedge mclk);
    #1;
    `TB_CHK("pin gate in reset", co, pin_gate)
    `TB_CHK("pin enable in reset", co, pin_oe)
    @(posedge mclk);
    srst <= 1'b0;
  endtask

  function automatic int period(input logic [3:0] s);
    return (s > 4'h8) ? 256 : (1 << s);
  endfunction

  initial begin
    mismatches = 0;
    checks_done = 0;
    srst = 1'b1;
    bus = '0;
    fuse_clk_out = 1'b1;
    fuse_div8 = 1'b1;
    rc_src = 1'b1;
    factory_trim = 8'h5a;
    do_reset(1'b1, 1'b1);
    chk_rd(`SCT_ADDR_DIVCTL, 8'h03, "select after reset");
    chk_rd(`SCT_ADDR_TRIM, 8'h5a, "trim after reset");
    wait_tick(g1);
    wait_tick(g1);
    `TB_CHK("reset factor", 8, g1)
    wr_reg(`SCT_ADDR_TRIM, 8'h7f);
    chk_rd(`SCT_ADDR_TRIM, 8'h7f, "trim write");
    `TB_CHK("trim range low", 1'b0, trim_range)
    `TB_CHK("trim fine top", 7'h7f, trim_fine)
    wr_reg(`SCT_ADDR_TRIM, 8'h80);
    chk_rd(`SCT_ADDR_TRIM, 8'h80, "trim write");
    `TB_CHK("trim range high", 1'b1, trim_range)
    `TB_CHK("trim fine bottom", 7'h00, trim_fine)
    // Unlock with a stray bit set must not open the window.
    wr_reg(`SCT_ADDR_DIVCTL, 8'h81);
    wr_reg(`SCT_ADDR_DIVCTL, 8'h05);
    chk_rd(`SCT_ADDR_DIVCTL, 8'h03, "stray unlock");
    // Window runs out by itself, then a select write is ignored.
    wr_reg(`SCT_ADDR_DIVCTL, `SCT_UNLOCK_VALUE);
    repeat (5) @(posedge mclk);
    chk_rd(`SCT_ADDR_DIVCTL, 8'h03, "unlock expired");
    wr_reg(`SCT_ADDR_DIVCTL, 8'h05);
    chk_rd(`SCT_ADDR_DIVCTL, 8'h03, "late select");
    // A second unlock neither clears nor extends the window.
    wr_reg(`SCT_ADDR_DIVCTL, `SCT_UNLOCK_VALUE);
    wr_reg(`SCT_ADDR_DIVCTL, `SCT_UNLOCK_VALUE);
    chk_rd(`SCT_ADDR_DIVCTL, 8'h83, "unlock after rewrite");
    wr_reg(`SCT_ADDR_DIVCTL, 8'h05);
    chk_rd(`SCT_ADDR_DIVCTL, 8'h03, "no extension");
    // Every select code, ending with a 256 to 1 step.
    cur_sel = 4'h3;
    for (int s = 0; s < 17; s++) begin
      sv = s[3:0];
      oldp = period(cur_sel);
      newp = period(sv);
      set_sel(sv);
      chk_rd(`SCT_ADDR_DIVCTL, {4'h0, sv}, "select readback");
      wait_tick(g1);
      wait_tick(g2);
      wait_tick(g3);
      `TB_CHK("switch delay", 1'b1, (g1 + g2 <= oldp + 2 * newp))
      `TB_CHK("new period", newp, g3)
      cur_sel = sv;
    end
    wr_reg(`SCT_ADDR_ASYNC, 8'h03);
    repeat (2) @(posedge mclk);
    #1;
    `TB_CHK("timer osc on", 1'b1, tosc_en)
    `TB_CHK("external clock on", 1'b1, tosc_ext)
    chk_rd(`SCT_ADDR_ASYNC, 8'h03, "async readback");
    wr_reg(`SCT_ADDR_ASYNC, 8'h01);
    repeat (2) @(posedge mclk);
    #1;
    `TB_CHK("external clock off", 1'b0, tosc_ext)
    chk_rd(`SCT_ADDR_STATUS, 8'h0b, "status");
    @(posedge mclk);
    rc_src <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    `TB_CHK("timer osc without rc", 1'b0, tosc_en)
    @(posedge mclk);
    rc_src <= 1'b1;
    wr_reg(4'h9, 8'hff);
    chk_rd(4'h9, 8'h00, "unmapped read");
    do_reset(1'b0, 1'b0);
    chk_rd(`SCT_ADDR_DIVCTL, 8'h00, "select no fuse");
    wait_tick(g1);
    wait_tick(g1);
    `TB_CHK("undivided factor", 1, g1)
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
